// ==== verilog/pifb_bank.sv ====
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`include "pifb_defs.svh"

// Notes on behaviour
// R1 - Oscillator failure sets sticky flag bit 7
// R2 - Comparator change sets sticky flag bit 6
// R3 - Unimplemented bits read zero, ignore writes
// R4 - Bus collision sets sticky flag bit 3
// R5 - Low supply sets sticky flag bit 2
// R6 - Timer 3 overflow sets flag bit 1
// R7 - Receive-full bit is live, read-only
// R8 - Transmit-empty bit is live, read-only
// R9 - Second capcmp event sets bit 2, not PWM
// R10 - First capcmp event sets bit 1, not PWM
// R11 - Without priorities, group enable gates requests
// R12 - First enable register: seven-source layout, bit 2 unimplemented
// R13 - Second enable register mirrors second flags
// R14 - Third enable register mirrors third flags
// R15 - All flags and enables zero after reset
// R16 - Flags set regardless of any enable
// R17 - Priority enable selects priority or legacy mode
// R18 - Request is OR of flag-and-enable pairs
// R19 - Software clears flags before enabling, after service
module pifb_bank (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        osc_fail_evt,
  input  wire logic        comparator_change_evt,
  input  wire logic        bus_collision_evt,
  input  wire logic        low_voltage_evt,
  input  wire logic        timer3_overflow_evt,
  input  wire logic        serial2_rx_full,
  input  wire logic        serial2_tx_empty,
  input  wire logic        capcmp2_evt,
  input  wire logic        capcmp2_pwm_mode,
  input  wire logic        capcmp1_evt,
  input  wire logic        capcmp1_pwm_mode,
  input  wire logic [7:0]  peripheral_flags_one,
  input  wire logic        priority_levels_enable,
  input  wire logic        peripheral_group_enable,
  output logic             peripheral_request,
  output logic             core_peripheral_irq,
  output logic             irq
);

  pifb_pkg::pifb_state_t st_reg;
  pifb_pkg::pifb_state_t st_next;

  logic [4:0] sel;
  logic       wr_fire;
  logic       rd_start;
  logic [7:0] wd;
  logic [7:0] f3_view;
  logic [7:0] ev2;
  logic [7:0] ev3;
  logic [7:0] evs;
  logic [7:0] rd_mux;
  logic       acc_f2;
  logic       acc_f3;

  assign sel      = {avs_address[4:2], 2'b00};
  assign wd       = avs_writedata[7:0];
  // A write lands only on the edge where waitrequest is seen low
  assign wr_fire  = avs_write & st_reg.ack & avs_byteenable[0];
  assign rd_start = avs_read & ~st_reg.ack;
  assign acc_f2   = wr_fire && (sel == `PIFB_OFS_FLAGS_TWO);
  assign acc_f3   = wr_fire && (sel == `PIFB_OFS_FLAGS_THREE);

  // Port status bits follow the serial port directly; the port itself
  // drops them when its buffer is read or written
  always_comb begin
    f3_view = st_reg.f3 & `PIFB_MASK_F3_SW;
    f3_view[`PIFB_B_RX] = serial2_rx_full;   // see R7
    f3_view[`PIFB_B_TX] = serial2_tx_empty;  // see R8
  end

  assign peripheral_request = |(st_reg.f2 & st_reg.e2) |
                              |(f3_view & st_reg.e3) |
                              |(peripheral_flags_one & st_reg.e1);  // see R18
  // Priority mode hands the request on; legacy mode needs the group enable
  assign core_peripheral_irq = peripheral_request &
                               (priority_levels_enable | peripheral_group_enable);  // see R11, see R17
  assign irq             = |(st_reg.ist & st_reg.imsk);
  assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
  assign avs_readdata    = {`PIFB_ZERO_HI, st_reg.rdata};

  always_comb begin
    st_next = st_reg;

    // Events are gathered regardless of enables so software may poll
    ev2 = `PIFB_RST_BYTE;
    ev2[`PIFB_B_OSC] = osc_fail_evt;           // see R1, see R16
    ev2[`PIFB_B_CMP] = comparator_change_evt;  // see R2
    ev2[`PIFB_B_BCL] = bus_collision_evt;      // see R4
    ev2[`PIFB_B_LVD] = low_voltage_evt;        // see R5
    ev2[`PIFB_B_T3]  = timer3_overflow_evt;    // see R6
    ev3 = `PIFB_RST_BYTE;
    ev3[`PIFB_B_CC2] = capcmp2_evt & ~capcmp2_pwm_mode;  // see R9
    ev3[`PIFB_B_CC1] = capcmp1_evt & ~capcmp1_pwm_mode;  // see R10

    evs = ev2 & `PIFB_MASK_TWO;
    evs[`PIFB_S_CC2] = ev3[`PIFB_B_CC2];
    evs[`PIFB_S_CC1] = ev3[`PIFB_B_CC1];
    evs[`PIFB_S_REQ] = core_peripheral_irq & ~st_reg.req_q;

    rd_mux = `PIFB_RST_BYTE;
    unique case (sel)
      `PIFB_OFS_FLAGS_TWO:   rd_mux = st_reg.f2;
      `PIFB_OFS_FLAGS_THREE: rd_mux = f3_view;
      `PIFB_OFS_EN_ONE:      rd_mux = st_reg.e1;
      `PIFB_OFS_EN_TWO:      rd_mux = st_reg.e2;
      `PIFB_OFS_EN_THREE:    rd_mux = st_reg.e3;
      `PIFB_OFS_IRQ_STATUS:  rd_mux = st_reg.ist;
      `PIFB_OFS_IRQ_MASK:    rd_mux = st_reg.imsk;
      default:               rd_mux = `PIFB_RST_BYTE;
    endcase

    // Software writes the flags; an event in the same cycle wins
    if (acc_f2) begin
      st_next.f2 = wd & `PIFB_MASK_TWO;  // see R3
    end
    st_next.f2 = st_next.f2 | (ev2 & `PIFB_MASK_TWO);
    if (acc_f3) begin
      st_next.f3 = wd & `PIFB_MASK_F3_SW;  // see R3
    end
    st_next.f3 = st_next.f3 | ev3;

    if (wr_fire && (sel == `PIFB_OFS_EN_ONE)) begin
      st_next.e1 = wd & `PIFB_MASK_ONE;  // see R12
    end
    if (wr_fire && (sel == `PIFB_OFS_EN_TWO)) begin
      st_next.e2 = wd & `PIFB_MASK_TWO;  // see R13
    end
    if (wr_fire && (sel == `PIFB_OFS_EN_THREE)) begin
      st_next.e3 = wd & `PIFB_MASK_THREE;  // see R14
    end

    if (wr_fire && (sel == `PIFB_OFS_IRQ_STATUS)) begin
      st_next.ist = st_reg.ist & ~wd;
    end
    st_next.ist = st_next.ist | evs;
    if (wr_fire && (sel == `PIFB_OFS_IRQ_MASK)) begin
      st_next.imsk = wd;
    end

    st_next.req_q = core_peripheral_irq;
    // One wait cycle per access keeps read data in a flip-flop
    st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
    if (rd_start) begin
      st_next.rdata = rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;  // see R15
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  osc_flag_set_a: // see R1
    assert property (osc_fail_evt |=> st_reg.f2[`PIFB_B_OSC])
    else $error("oscillator fail flag not set");

  osc_flag_hold_a: // see R1
    assert property ((st_reg.f2[`PIFB_B_OSC] && !acc_f2) |=> st_reg.f2[`PIFB_B_OSC])
    else $error("oscillator fail flag dropped without a write");

  cmp_flag_poll_a: // see R2, see R16
    assert property ((comparator_change_evt && !peripheral_group_enable && !st_reg.e2[`PIFB_B_CMP])
                     |=> st_reg.f2[`PIFB_B_CMP])
    else $error("comparator flag gated by enable");

  unimpl_bits_zero_a: // see R3
    assert property (((st_reg.f2 & ~`PIFB_MASK_TWO) == `PIFB_RST_BYTE) &&
                     ((st_reg.f3 & ~`PIFB_MASK_F3_SW) == `PIFB_RST_BYTE) &&
                     ((st_reg.e1 & ~`PIFB_MASK_ONE) == `PIFB_RST_BYTE) &&
                     ((st_reg.e2 & ~`PIFB_MASK_TWO) == `PIFB_RST_BYTE) &&
                     ((st_reg.e3 & ~`PIFB_MASK_THREE) == `PIFB_RST_BYTE))
    else $error("unimplemented bit holds a one");

  bcl_set_wins_a: // see R4
    assert property ((bus_collision_evt && acc_f2) |=> st_reg.f2[`PIFB_B_BCL])
    else $error("collision lost against a clearing write");

  lvd_flag_set_a: // see R5
    assert property ($rose(low_voltage_evt) |-> ##1 st_reg.f2[`PIFB_B_LVD])
    else $error("low voltage flag not set");

  t3_flag_clear_a: // see R6
    assert property ((acc_f2 && !wd[`PIFB_B_T3] && !timer3_overflow_evt)
                     |=> !st_reg.f2[`PIFB_B_T3])
    else $error("timer 3 flag not cleared by write");

  rx_live_read_a: // see R7
    assert property ((rd_start && sel == `PIFB_OFS_FLAGS_THREE)
                     |=> avs_readdata[`PIFB_B_RX] == $past(serial2_rx_full))
    else $error("receive full bit does not follow port");

  tx_live_read_a: // see R8
    assert property ((rd_start && sel == `PIFB_OFS_FLAGS_THREE)
                     |=> avs_readdata[`PIFB_B_TX] == $past(serial2_tx_empty))
    else $error("transmit empty bit does not follow port");

  cc2_pwm_ignore_a: // see R9
    assert property ((capcmp2_evt && capcmp2_pwm_mode && !st_reg.f3[`PIFB_B_CC2] && !acc_f3)
                     |=> !st_reg.f3[`PIFB_B_CC2])
    else $error("capcmp2 flag set in pwm mode");

  cc1_flag_set_a: // see R10
    assert property ((capcmp1_evt && !capcmp1_pwm_mode) |=> st_reg.f3[`PIFB_B_CC1])
    else $error("capcmp1 flag not set");

  legacy_gate_a: // see R11
    assert property ((!priority_levels_enable && !peripheral_group_enable) |-> !core_peripheral_irq)
    else $error("request passed without group enable");

  prio_pass_a: // see R17
    assert property ((priority_levels_enable && peripheral_request) |-> core_peripheral_irq)
    else $error("priority mode blocked a request");

  en_one_write_a: // see R12
    assert property ((wr_fire && sel == `PIFB_OFS_EN_ONE)
                     |=> st_reg.e1 == ($past(wd) & `PIFB_MASK_ONE))
    else $error("first enable register write lost");

  en_mirror_write_a: // see R14
    assert property ((wr_fire && sel == `PIFB_OFS_EN_THREE)
                     |=> st_reg.e3 == ($past(wd) & `PIFB_MASK_THREE))
    else $error("third enable register write lost");

  reset_clear_a: // see R15
    assert property ($fell(sys_rst) |-> (st_reg.f2 == `PIFB_RST_BYTE && st_reg.f3 == `PIFB_RST_BYTE &&
                     st_reg.e1 == `PIFB_RST_BYTE && st_reg.e2 == `PIFB_RST_BYTE &&
                     st_reg.e3 == `PIFB_RST_BYTE))
    else $error("register not zero after reset");

  req_from_pair_a: // see R18
    assert property ((timer3_overflow_evt && st_reg.e2[`PIFB_B_T3] && !wr_fire) |=> peripheral_request)
    else $error("enabled flag raised no request");

  bus_one_wait_a:
    assert property (((avs_read || avs_write) && !st_reg.ack) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access not answered after one wait cycle");

  cmp_flag_set_a: // see R2
    assert property (comparator_change_evt |=> st_reg.f2[`PIFB_B_CMP])
    else $error("comparator flag not set");

  cmp_flag_hold_a: // see R2
    assert property ((st_reg.f2[`PIFB_B_CMP] && !acc_f2) |=> st_reg.f2[`PIFB_B_CMP])
    else $error("comparator flag dropped without a write");

  bcl_flag_set_a: // see R4
    assert property (bus_collision_evt |=> st_reg.f2[`PIFB_B_BCL])
    else $error("collision flag not set");

  bcl_flag_hold_a: // see R4
    assert property ((st_reg.f2[`PIFB_B_BCL] && !acc_f2) |=> st_reg.f2[`PIFB_B_BCL])
    else $error("collision flag dropped without a write");

  lvd_flag_hold_a: // see R5
    assert property ((st_reg.f2[`PIFB_B_LVD] && !acc_f2) |=> st_reg.f2[`PIFB_B_LVD])
    else $error("low voltage flag dropped without a write");

  t3_flag_set_a: // see R6
    assert property (timer3_overflow_evt |=> st_reg.f2[`PIFB_B_T3])
    else $error("timer 3 flag not set");

  t3_flag_hold_a: // see R6
    assert property ((st_reg.f2[`PIFB_B_T3] && !acc_f2) |=> st_reg.f2[`PIFB_B_T3])
    else $error("timer 3 flag dropped without a write");

  f2_write_a: // see R3
    assert property ((acc_f2 && ev2 == `PIFB_RST_BYTE)
                     |=> st_reg.f2 == ($past(wd) & `PIFB_MASK_TWO))
    else $error("second flag register write wrong");

  f3_write_a: // see R3
    assert property ((acc_f3 && ev3 == `PIFB_RST_BYTE)
                     |=> st_reg.f3 == ($past(wd) & `PIFB_MASK_F3_SW))
    else $error("third flag register write wrong");

  cc2_flag_set_a: // see R9
    assert property ((capcmp2_evt && !capcmp2_pwm_mode) |=> st_reg.f3[`PIFB_B_CC2])
    else $error("capcmp2 flag not set");

  cc2_flag_hold_a: // see R9
    assert property ((st_reg.f3[`PIFB_B_CC2] && !acc_f3) |=> st_reg.f3[`PIFB_B_CC2])
    else $error("capcmp2 flag dropped without a write");

  cc1_pwm_ignore_a: // see R10
    assert property ((capcmp1_evt && capcmp1_pwm_mode && !st_reg.f3[`PIFB_B_CC1] && !acc_f3)
                     |=> !st_reg.f3[`PIFB_B_CC1])
    else $error("capcmp1 flag set in pwm mode");

  cc1_flag_hold_a: // see R10
    assert property ((st_reg.f3[`PIFB_B_CC1] && !acc_f3) |=> st_reg.f3[`PIFB_B_CC1])
    else $error("capcmp1 flag dropped without a write");

  en_two_write_a: // see R13
    assert property ((wr_fire && sel == `PIFB_OFS_EN_TWO)
                     |=> st_reg.e2 == ($past(wd) & `PIFB_MASK_TWO))
    else $error("second enable register write lost");

  en_hold_a: // see R12, see R13, see R14
    assert property (!wr_fire
                     |=> ($stable(st_reg.e1) && $stable(st_reg.e2) && $stable(st_reg.e3)))
    else $error("enable changed without a write");

  lane_off_write_a: // see R12
    assert property ((avs_write && st_reg.ack && !avs_byteenable[0]) |=> $stable(st_reg.e1))
    else $error("write landed with lane disabled");

  group_pass_a: // see R11
    assert property ((peripheral_group_enable && peripheral_request) |-> core_peripheral_irq)
    else $error("group enable blocked a request");

  req_needs_enable_a: // see R18
    assert property (((st_reg.e1 | st_reg.e2 | st_reg.e3) == `PIFB_RST_BYTE) |-> !peripheral_request)
    else $error("request raised with no enable set");

  unmapped_read_zero_a: // see R3
    assert property ((rd_start && sel > `PIFB_OFS_IRQ_MASK)
                     |=> avs_readdata[7:0] == `PIFB_RST_BYTE)
    else $error("unmapped offset read not zero");

  read_high_zero_a: // see R3
    assert property (avs_readdata[31:8] == `PIFB_ZERO_HI)
    else $error("upper read data not zero");

  rdata_hold_a:
    assert property (!rd_start |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  ack_pulse_a:
    assert property (st_reg.ack |=> !st_reg.ack)
    else $error("acknowledge held for two cycles");

  idle_no_wait_a:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");

  status_set_wins_a:
    assert property (osc_fail_evt |=> st_reg.ist[`PIFB_B_OSC])
    else $error("status bit not set by event");

  status_clear_a:
    assert property ((wr_fire && sel == `PIFB_OFS_IRQ_STATUS && wd[`PIFB_B_OSC] && !osc_fail_evt)
                     |=> !st_reg.ist[`PIFB_B_OSC])
    else $error("status bit not cleared by a one");

  status_hold_a:
    assert property ((st_reg.ist[`PIFB_B_T3] && !wr_fire) |=> st_reg.ist[`PIFB_B_T3])
    else $error("status bit dropped without a write");

  req_rise_status_a:
    assert property ($rose(core_peripheral_irq) |=> st_reg.ist[`PIFB_S_REQ])
    else $error("request rise not recorded");

  irq_masked_a:
    assert property ((st_reg.imsk == `PIFB_RST_BYTE) |-> !irq)
    else $error("interrupt raised with all masked");

  osc_irq_c: cover property (osc_fail_evt ##1 st_reg.e2[`PIFB_B_OSC] ##1 peripheral_request);
  f3_read_c: cover property (rd_start && sel == `PIFB_OFS_FLAGS_THREE && serial2_rx_full);
  w1c_c:     cover property (st_reg.ist != `PIFB_RST_BYTE ##1 wr_fire && sel == `PIFB_OFS_IRQ_STATUS);
  core_irq_c: cover property ($rose(core_peripheral_irq) ##1 irq);
  set_wins_c: cover property (bus_collision_evt && acc_f2);

endmodule

// ==== verilog/pifb_defs.svh ====
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// Byte offsets on the register bus
`define PIFB_OFS_FLAGS_TWO   5'h00
`define PIFB_OFS_FLAGS_THREE 5'h04
`define PIFB_OFS_EN_ONE      5'h08
`define PIFB_OFS_EN_TWO      5'h0c
`define PIFB_OFS_EN_THREE    5'h10
`define PIFB_OFS_IRQ_STATUS  5'h14
`define PIFB_OFS_IRQ_MASK    5'h18

// Flag bit positions, second flag register
`define PIFB_B_OSC 7
`define PIFB_B_CMP 6
`define PIFB_B_BCL 3
`define PIFB_B_LVD 2
`define PIFB_B_T3  1

// Flag bit positions, third flag register
`define PIFB_B_RX  5
`define PIFB_B_TX  4
`define PIFB_B_CC2 2
`define PIFB_B_CC1 1

// Status-only positions for the capture/compare events and the core request
`define PIFB_S_CC2 5
`define PIFB_S_CC1 4
`define PIFB_S_REQ 0

// Implemented-bit masks
`define PIFB_MASK_TWO    8'hce
`define PIFB_MASK_THREE  8'h36
`define PIFB_MASK_F3_SW  8'h06
`define PIFB_MASK_ONE    8'hfb

`define PIFB_RST_BYTE 8'h00
`define PIFB_ZERO_HI  24'h000000

`endif

// ==== verilog/pifb_pkg.sv ====
package pifb_pkg;

  typedef struct packed {
    logic [7:0] f2;
    logic [7:0] f3;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] e3;
    logic [7:0] ist;
    logic [7:0] imsk;
    logic [7:0] rdata;
    logic       ack;
    logic       req_q;
  } pifb_state_t;

endpackage

// ==== dv/pifb_periph_model.sv ====
`timescale 1ns/100ps
// Peripheral side: rising commands become one-cycle event pulses, levels pass registered
module pifb_periph_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [10:0] cmd,
  output logic      [10:0] sig
);
  logic [6:0] prev;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev <= 7'h00;
      sig  <= 11'h000;
    end else begin
      prev      <= cmd[6:0];
      sig[6:0]  <= cmd[6:0] & ~prev;
      sig[10:7] <= cmd[10:7];
    end
  end
endmodule

// ==== dv/peripheral_irq_flag_enable_bank_tb_top.sv ====
`timescale 1ns/100ps
module peripheral_irq_flag_enable_bank_tb_top;
  logic        clk_sys, sys_rst, avs_read, avs_write, prio, grp;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [10:0] cmd;
  logic [7:0]  flags1, q;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, preq, cirq, irq;
  wire  [10:0] ps;
  int          n_fail, comparisons, i;
  logic [7:0]  f2b [5] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02};
  logic [4:0]  ofs [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
  logic [7:0]  msk [5] = '{8'hce, 8'h06, 8'hfb, 8'hce, 8'h36};

  pifb_periph_model pm (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(cmd), .sig(ps));
  pifb_bank dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_fail_evt(ps[0]),
    .comparator_change_evt(ps[1]), .bus_collision_evt(ps[2]), .low_voltage_evt(ps[3]),
    .timer3_overflow_evt(ps[4]), .capcmp2_evt(ps[5]), .capcmp1_evt(ps[6]), .capcmp2_pwm_mode(ps[7]),
    .capcmp1_pwm_mode(ps[8]), .serial2_rx_full(ps[9]), .serial2_tx_empty(ps[10]),
    .peripheral_flags_one(flags1), .priority_levels_enable(prio), .peripheral_group_enable(grp),
    .peripheral_request(preq), .core_peripheral_irq(cirq), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge; data is taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", "waitrequest", 1'b0, avs_waitrequest);
      complete_run();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(nm, e, q);
  endtask

  task automatic fire(input int k);
    @(posedge clk_sys);
    cmd[k] <= 1'b1;
    @(posedge clk_sys);
    cmd[k] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic pins(input logic p, input logic g);
    @(posedge clk_sys);
    prio <= p;
    grp <= g;
    @(negedge clk_sys);
  endtask

  task automatic t_reset();
    for (i = 0; i < 8; i++) rd(5'(i * 4), 8'h00, "reset value");
  endtask

  task automatic t_masks();
    for (i = 0; i < 5; i++) begin
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i], "writable bits");
    end
    bus(1'b1, 5'h08, 8'h00, 4'h0);
    rd(5'h08, 8'hfb, "lane disabled write");
    for (i = 0; i < 5; i++) wr(ofs[i], 8'h00);
  endtask

  task automatic t_flags_two();
    for (i = 0; i < 5; i++) begin
      fire(i);
      rd(5'h00, f2b[i], "event flag");
      rd(5'h14, f2b[i], "event status");
      wr(5'h00, 8'h00);
      wr(5'h14, 8'hff);
      rd(5'h00, 8'h00, "flag cleared");
    end
  endtask

  // Collision pulse lands on the same edge as a clearing write
  task automatic t_set_wins();
    fork
      wr(5'h00, 8'h00);
      begin
        @(posedge clk_sys);
        cmd[2] <= 1'b1;
      end
    join
    cmd[2] <= 1'b0;
    rd(5'h00, 8'h08, "set beats clear");
    wr(5'h00, 8'h00);
    wr(5'h14, 8'hff);
  endtask

  task automatic t_capcmp();
    fire(5);
    rd(5'h04, 8'h04, "capcmp2 flag");
    fire(6);
    rd(5'h04, 8'h06, "capcmp1 flag");
    wr(5'h04, 8'h00);
    cmd[8:7] <= 2'b11;
    fire(5);
    fire(6);
    rd(5'h04, 8'h00, "pwm ignored");
    cmd[8:7] <= 2'b00;
    wr(5'h14, 8'hff);
  endtask

  task automatic t_live();
    cmd[9] <= 1'b1;
    rd(5'h04, 8'h20, "rx full live");
    wr(5'h04, 8'h00);
    rd(5'h04, 8'h20, "rx read only");
    cmd[10:9] <= 2'b10;
    rd(5'h04, 8'h10, "tx empty live");
    cmd[10] <= 1'b0;
    rd(5'h04, 8'h00, "live cleared");
  endtask

  task automatic t_gate();
    rd(5'h00, 8'h00, "flag clear first");
    wr(5'h0c, 8'h02);
    fire(4);
    pins(1'b0, 1'b0);
    chk("request", 8'h01, {7'h00, preq});
    chk("core gated", 8'h00, {7'h00, cirq});
    pins(1'b0, 1'b1);
    chk("core group", 8'h01, {7'h00, cirq});
    pins(1'b1, 1'b0);
    chk("core priority", 8'h01, {7'h00, cirq});
    wr(5'h00, 8'h00);
    flags1 <= 8'h01;
    @(negedge clk_sys);
    chk("request off", 8'h00, {7'h00, preq});
    wr(5'h08, 8'h01);
    @(negedge clk_sys);
    chk("request one", 8'h01, {7'h00, preq});
    wr(5'h08, 8'h00);
    wr(5'h0c, 8'h00);
    pins(1'b0, 1'b0);
    wr(5'h14, 8'hff);
  endtask

  task automatic t_irq();
    fire(0);
    rd(5'h14, 8'h80, "status set");
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(5'h18, 8'h80);
    @(negedge clk_sys);
    chk("irq raised", 8'h01, {7'h00, irq});
    wr(5'h14, 8'h80);
    rd(5'h14, 8'h00, "status cleared");
    chk("irq dropped", 8'h00, {7'h00, irq});
    rd(5'h00, 8'h80, "flag kept");
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    {avs_read, avs_write, prio, grp} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    cmd = 11'h000;
    flags1 = 8'h00;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_masks();
    t_flags_two();
    t_set_wins();
    t_capcmp();
    t_live();
    t_gate();
    t_irq();
    complete_run();
  end
endmodule
